// >>> dv/tmr_capture_ppg_sva.sv
// port checker for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tmr_capture_ppg_chk (
   input wire logic                   ref_clk,              // clock
   input wire logic                   sys_rst,              // async reset
   input wire logic                   clk_en,               // enable
   input wire logic [tmr_pkg::AW-1:0] reg_addr,             // index
   input wire logic [tmr_pkg::DW-1:0] reg_wdata,            // write data
   input wire logic                   reg_wr,               // write strobe
   input wire logic                   reg_rd,               // read strobe
   input wire logic [tmr_pkg::DW-1:0] reg_rdata,            // read data
   input wire logic                   trigger_capture_in_a, // input a
   input wire logic                   capture_in_b,         // input b
   input wire logic                   timer_output_pin,     // output
   input wire logic                   match_capture_irq_a,  // primary event
   input wire logic                   irq                   // interrupt
);
////////////////////////////////////////
   logic [4:0] ctrl_ff;
   logic [2:0] mask_ff;
   logic [1:0] pre_ff;
   logic       off;

   // shadow copies of the control, mask and prescaler registers
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= 5'h00;
         mask_ff <= 3'h0;
         pre_ff <= 2'h0;
      end else if (reg_wr && clk_en) begin
         if (reg_addr == tmr_pkg::OFS_CTRL) ctrl_ff <= reg_wdata[4:0];
         if (reg_addr == tmr_pkg::OFS_MASK) mask_ff <= reg_wdata[2:0];
         if (reg_addr == tmr_pkg::OFS_PRE) pre_ff <= reg_wdata[1:0];
      end
   end
   assign off = ctrl_ff[1:0] == 2'b00 || !ctrl_ff[2];
////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_rd_idle;
      !$past(reg_rd && clk_en) |-> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
   property p_unmapped;
      $past(reg_rd && clk_en && reg_addr > 4'h7) |-> reg_rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_ctrl_rb;
      $past(reg_rd && clk_en && reg_addr == tmr_pkg::OFS_CTRL) |-> reg_rdata == {11'h000, ctrl_ff};
   endproperty
   a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
   property p_mask_rb;
      $past(reg_rd && clk_en && reg_addr == tmr_pkg::OFS_MASK) |-> reg_rdata == {13'h0, mask_ff};
   endproperty
   a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
   property p_out_off;
      off && $past(off) |-> !timer_output_pin;
   endproperty
   a_out_off: assert property (p_out_off) else $error("output high while off");
   property p_irq_masked;
      mask_ff == 3'h0 && $past(mask_ff) == 3'h0 |-> !irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
   property p_irqa_one;
      $rose(match_capture_irq_a) && pre_ff == 2'b00 && clk_en |=> !match_capture_irq_a;
   endproperty
   a_irqa_one: assert property (p_irqa_one) else $error("event pulse length");
   property p_irqa_four;
      $rose(match_capture_irq_a) && pre_ff == 2'b01 |-> match_capture_irq_a[*4] ##1 !match_capture_irq_a;
   endproperty
   a_irqa_four: assert property (p_irqa_four) else $error("event pulse length");
   property p_freeze;
      !clk_en |=> $stable(timer_output_pin) && $stable(match_capture_irq_a) && $stable(irq);
   endproperty
   a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
endmodule

bind tmr_capture_ppg tmr_capture_ppg_chk tmr_capture_ppg_chk_i (.ref_clk, .sys_rst, .clk_en,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trigger_capture_in_a, .capture_in_b,
   .timer_output_pin, .match_capture_irq_a, .irq);
`default_nettype wire

// >>> dv/tmr_capture_ppg_tb_top.sv
// self-checking testbench for the capture/compare timer
`timescale 1ns/100ps
`default_nettype none
module tmr_capture_ppg_tb_top;
   logic        ref_clk;
   logic        sys_rst;
   logic        clk_en;
   logic [3:0]  reg_addr;
   logic [15:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [15:0] reg_rdata;
   logic        trigger_capture_in_a;
   logic        capture_in_b;
   logic        timer_output_pin;
   logic        match_capture_irq_a;
   logic        irq;
   logic        set_a;
   logic        set_b;
   logic        slow;
   int          err_total;
   int          total_checks;

   tmr_capture_ppg tmr_capture_ppg_i (.ref_clk, .sys_rst, .clk_en, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .trigger_capture_in_a, .capture_in_b, .timer_output_pin,
      .match_capture_irq_a, .irq);
   tmr_pin_model tmr_pin_model_i (.ref_clk, .sys_rst, .set_a, .set_b, .slow,
      .trigger_capture_in_a, .capture_in_b);
////////////////////////////////////////
   task automatic give_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: level %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      total_checks++;
      if (got != exp) begin
         err_total++;
         $display("Error at %0t: count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // time high and full period of the next output pulse, counting primary events
   task automatic meas(output int hi, output int per, output int nirq);
      int n;
      n = 0;
      hi = 0;
      nirq = 0;
      while (timer_output_pin === 1'b1 && n < 300) begin
         @(posedge ref_clk);
         n++;
      end
      while (timer_output_pin !== 1'b1 && n < 600) begin
         @(posedge ref_clk);
         n++;
      end
      while (timer_output_pin === 1'b1 && hi < 300) begin
         nirq += (match_capture_irq_a === 1'b1);
         @(posedge ref_clk);
         hi++;
      end
      per = hi;
      while (timer_output_pin !== 1'b1 && per < 300) begin
         nirq += (match_capture_irq_a === 1'b1);
         @(posedge ref_clk);
         per++;
      end
   endtask
////////////////////////////////////////
   task automatic t_reset;
      logic [15:0] d;
      logic [3:0]  ofs [6];
      logic [15:0] exp [6];
      ofs = '{tmr_pkg::OFS_PER, tmr_pkg::OFS_DUTY, tmr_pkg::OFS_CTRL, tmr_pkg::OFS_CNT,
              tmr_pkg::OFS_STAT, 4'hf};
      exp = '{tmr_pkg::PER_RST, tmr_pkg::DUTY_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
      wr(4'hf, 16'h5a5a);
      foreach (ofs[i]) begin
         rd(ofs[i], d);
         chk_word(d, exp[i]);
      end
   endtask
   task automatic t_count;
      logic [15:0] c0;
      logic [15:0] c1;
      wr(tmr_pkg::OFS_CTRL, 16'h0002);
      rd(tmr_pkg::OFS_CNT, c0);
      chk_bit(c0 <= 16'h0002, 1'b1);
      repeat (10) @(posedge ref_clk);
      rd(tmr_pkg::OFS_CNT, c1);
      chk_word(c1 - c0, 16'h000c);
      wr(tmr_pkg::OFS_CTRL, 16'h0000);
      rd(tmr_pkg::OFS_CNT, c0);
      chk_word(c0, 16'h0000);
   endtask
   task automatic t_ppg;
      int hi;
      int per;
      int nirq;
      wr(tmr_pkg::OFS_PER, 16'h0009);
      wr(tmr_pkg::OFS_DUTY, 16'h0003);
      wr(tmr_pkg::OFS_CTRL, 16'h000f);
      meas(hi, per, nirq);
      chk_cnt(hi, 4);
      chk_cnt(per, 10);
      chk_cnt(nirq, 1);
      clk_en <= 1'b0;
      repeat (6) @(posedge ref_clk);
      clk_en <= 1'b1;
      meas(hi, per, nirq);
      chk_cnt(per, 10);
      wr(tmr_pkg::OFS_CTRL, 16'h0007);
      meas(hi, per, nirq);
      chk_cnt(hi, 10);
      chk_cnt(per, 20);
      chk_cnt(nirq, 2);
      wr(tmr_pkg::OFS_CTRL, 16'h0000);
   endtask
   task automatic t_oneshot;
      int hi;
      int per;
      int nirq;
      wr(tmr_pkg::OFS_PER, 16'h0014);
      wr(tmr_pkg::OFS_DUTY, 16'h0005);
      wr(tmr_pkg::OFS_CAPC, 16'h0008);
      wr(tmr_pkg::OFS_CTRL, 16'h0036);
      meas(hi, per, nirq);
      chk_cnt(hi, 15);
      set_a <= 1'b1;
      meas(hi, per, nirq);
      chk_cnt(hi, 15);
      set_a <= 1'b0;
      wr(tmr_pkg::OFS_CTRL, 16'h0037);
      meas(hi, per, nirq);
      chk_cnt(hi, 0);
      wr(tmr_pkg::OFS_CTRL, 16'h0015);
      set_a <= 1'b1;
      meas(hi, per, nirq);
      chk_cnt(hi, 15);
      set_a <= 1'b0;
      wr(tmr_pkg::OFS_CTRL, 16'h0000);
   endtask
   task automatic t_capture;
      logic [15:0] d0;
      logic [15:0] d1;
      int          n;
      wr(tmr_pkg::OFS_PRE, 16'h0001);
      wr(tmr_pkg::OFS_PER, 16'h1234);
      wr(tmr_pkg::OFS_STAT, 16'h0007);
      wr(tmr_pkg::OFS_MASK, 16'h0001);
      wr(tmr_pkg::OFS_CAPC, 16'h003f);
      wr(tmr_pkg::OFS_CTRL, 16'h0002);
      set_a <= 1'b1;
      repeat (3) @(posedge ref_clk);
      set_a <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rd(tmr_pkg::OFS_DUTY, d0);
      chk_word(d0, 16'h0005);
      @(posedge ref_clk);
      slow <= 1'b1;
      set_a <= 1'b1;
      repeat (20) @(posedge ref_clk);
      rd(tmr_pkg::OFS_DUTY, d0);
      repeat (18) @(posedge ref_clk);
      set_a <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rd(tmr_pkg::OFS_DUTY, d1);
      chk_word(d1 - d0, 16'h000a);
      rd(tmr_pkg::OFS_PER, d0);
      chk_word(d0, 16'h1234);
      chk_bit(irq, 1'b0);
      @(posedge ref_clk);
      set_b <= 1'b1;
      n = 0;
      while (match_capture_irq_a !== 1'b1 && n < 40) begin
         @(posedge ref_clk);
         n++;
      end
      chk_bit(match_capture_irq_a, 1'b1);
      set_b <= 1'b0;
      repeat (6) @(posedge ref_clk);
      chk_bit(irq, 1'b1);
      rd(tmr_pkg::OFS_PER, d0);
      chk_word(d0, 16'h1234);
      wr(tmr_pkg::OFS_MASK, 16'h0000);
      repeat (2) @(posedge ref_clk);
      chk_bit(irq, 1'b0);
      wr(tmr_pkg::OFS_MASK, 16'h0001);
      repeat (2) @(posedge ref_clk);
      chk_bit(irq, 1'b1);
      rd(tmr_pkg::OFS_MASK, d0);
      chk_word(d0, 16'h0001);
      wr(tmr_pkg::OFS_STAT, 16'h0001);
      repeat (2) @(posedge ref_clk);
      chk_bit(irq, 1'b0);
      rd(tmr_pkg::OFS_STAT, d0);
      chk_bit(d0[0], 1'b0);
      wr(tmr_pkg::OFS_CTRL, 16'h0000);
      wr(tmr_pkg::OFS_PRE, 16'h0000);
   endtask
////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      give_verdict;
   end
   initial begin
      err_total = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      clk_en = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      set_a = 1'b0;
      set_b = 1'b0;
      slow = 1'b0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_reset;
      t_count;
      t_ppg;
      t_oneshot;
      t_capture;
      give_verdict;
   end
endmodule
`default_nettype wire

// >>> dv/tmr_pin_model.sv
// model of the external trigger and capture pins
`timescale 1ns/100ps
`default_nettype none
module tmr_pin_model (
   input  wire logic ref_clk,              // clock
   input  wire logic sys_rst,              // async reset
   input  wire logic set_a,                // wanted level on input a
   input  wire logic set_b,                // wanted level on input b
   input  wire logic slow,                 // answer one cycle later
   output logic      trigger_capture_in_a, // trigger pin
   output logic      capture_in_b          // capture pin
);
////////////////////////////////////////
   logic [1:0] dly_a_ff;
   logic [1:0] dly_b_ff;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dly_a_ff <= 2'h0;
         dly_b_ff <= 2'h0;
      end else begin
         dly_a_ff <= {dly_a_ff[0], set_a};
         dly_b_ff <= {dly_b_ff[0], set_b};
      end
   end

   // each pin follows its wanted level one cycle later, two when slow is set
   assign trigger_capture_in_a = slow ? dly_a_ff[1] : dly_a_ff[0];
   assign capture_in_b = slow ? dly_b_ff[1] : dly_b_ff[0];
endmodule
`default_nettype wire

// >>> src/tmr_capture_ppg.sv
// 16-bit timer with capture, square wave, ppg and one-shot output
`timescale 1ns/100ps
`default_nettype none
module tmr_capture_ppg (
   input  wire logic                    ref_clk,              // clock
   input  wire logic                    sys_rst,              // async reset
   input  wire logic                    clk_en,               // freeze when low
   input  wire logic [tmr_pkg::AW-1:0]  reg_addr,             // register index
   input  wire logic [tmr_pkg::DW-1:0]  reg_wdata,            // write data
   input  wire logic                    reg_wr,               // write strobe
   input  wire logic                    reg_rd,               // read strobe
   output logic      [tmr_pkg::DW-1:0]  reg_rdata,            // read data
   input  wire logic                    trigger_capture_in_a, // trigger input
   input  wire logic                    capture_in_b,         // capture input
   output logic                         timer_output_pin,     // timer output
   output logic                         match_capture_irq_a,  // primary event
   output logic                         irq                   // masked status
);

   ////////////////////////////////////////////////////////////////////
   // register state

   tmr_pkg::ctrl_t              ctrl_ff;
   tmr_pkg::capc_t              capc_ff;
   logic [tmr_pkg::DW-1:0]      per_ff;
   logic [tmr_pkg::DW-1:0]      duty_ff;
   logic [tmr_pkg::DW-1:0]      cnt_ff;
   tmr_pkg::stat_t              stat_ff;
   tmr_pkg::stat_t              mask_ff;
   logic [1:0]                  pre_sel_ff;
   logic [tmr_pkg::PRE_W-1:0]   pre_cnt_ff;
   logic                        soft_pend_ff;
   tmr_pkg::os_state_t          os_ff;
   logic                        out_ff;
   logic                        irqa_ff;
   logic                        irq_ff;
   logic [tmr_pkg::DW-1:0]      rdata_ff;

   ////////////////////////////////////////////////////////////////////
   // decode

   tmr_pkg::op_mode_t           mode;
   logic                        wr_ctrl;
   logic                        wr_per;
   logic                        wr_duty;
   logic                        wr_capc;
   logic                        wr_stat;
   logic                        wr_mask;
   logic                        wr_pre;

   assign mode    = tmr_pkg::op_mode_t'({ctrl_ff.op_mode_bit_hi, ctrl_ff.op_mode_bit_lo});
   assign wr_ctrl = reg_wr && (reg_addr == tmr_pkg::OFS_CTRL);
   assign wr_per  = reg_wr && (reg_addr == tmr_pkg::OFS_PER);
   assign wr_duty = reg_wr && (reg_addr == tmr_pkg::OFS_DUTY);
   assign wr_capc = reg_wr && (reg_addr == tmr_pkg::OFS_CAPC);
   assign wr_stat = reg_wr && (reg_addr == tmr_pkg::OFS_STAT);
   assign wr_mask = reg_wr && (reg_addr == tmr_pkg::OFS_MASK);
   assign wr_pre  = reg_wr && (reg_addr == tmr_pkg::OFS_PRE);

   ////////////////////////////////////////////////////////////////////
   // prescaler: count clock enable

   logic                        tick;
   logic [tmr_pkg::PRE_W-1:0]   pre_mask;

   always_comb begin
      case (pre_sel_ff)
         2'h0:    pre_mask = 6'h00;
         2'h1:    pre_mask = 6'h03;
         2'h2:    pre_mask = 6'h0f;
         default: pre_mask = 6'h3f;
      endcase
   end

   // free running, so a start lands anywhere inside a count clock
   assign tick = ((pre_cnt_ff & pre_mask) == pre_mask);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre_cnt_ff <= '0;
      end else if (clk_en) begin
         pre_cnt_ff <= pre_cnt_ff + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // input edges

   logic rise_a;
   logic fall_a;
   logic rise_b;
   logic fall_b;

   tmr_edge_filter u_filt_a (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .tick    (tick),
      .pin     (trigger_capture_in_a),
      .rise    (rise_a),
      .fall    (fall_a)
   );

   tmr_edge_filter u_filt_b (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .tick    (tick),
      .pin     (capture_in_b),
      .rise    (rise_b),
      .fall    (fall_b)
   );

   logic edge_a;
   logic rev_a;
   logic edge_b;

   always_comb begin
      case (capc_ff.edge_a)
         tmr_pkg::EDGE_FALL: begin
            edge_a = fall_a;
            rev_a  = rise_a;
         end
         tmr_pkg::EDGE_RISE: begin
            edge_a = rise_a;
            rev_a  = fall_a;
         end
         tmr_pkg::EDGE_BOTH: begin
            edge_a = rise_a || fall_a;
            rev_a  = 1'b0;
         end
         default: begin
            edge_a = 1'b0;
            rev_a  = 1'b0;
         end
      endcase
      case (capc_ff.edge_b)
         tmr_pkg::EDGE_FALL: edge_b = fall_b;
         tmr_pkg::EDGE_RISE: edge_b = rise_b;
         tmr_pkg::EDGE_BOTH: edge_b = rise_b || fall_b;
         default:            edge_b = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // counter events

   logic run;
   logic match_p;
   logic match_d;
   logic os_trig;
   logic cnt_clr;
   logic cap_p;
   logic cap_d;
   logic ev_a;
   logic ev_b;
   logic ev_ovf;

   assign run     = clk_en && tick && (mode != tmr_pkg::MODE_STOP);
   assign match_p = (cnt_ff == per_ff) && !capc_ff.per_cap_en;
   assign match_d = (cnt_ff == duty_ff) && !capc_ff.duty_cap_en;
   // soft trigger and input edge both fire, never in match-clear mode
   assign os_trig = ctrl_ff.oneshot_en
                    && ((mode == tmr_pkg::MODE_FREE) || (mode == tmr_pkg::MODE_CLR_E))
                    && (soft_pend_ff || edge_a);
   assign cnt_clr = ((mode == tmr_pkg::MODE_CLR_E) && edge_a)
                    || ((mode == tmr_pkg::MODE_CLR_M) && match_p)
                    || os_trig;
   // alternate source takes the reverse edge of input a
   assign cap_p   = capc_ff.per_cap_en
                    && (capc_ff.capture_source_sel ? rev_a : edge_b);
   assign cap_d   = capc_ff.duty_cap_en && edge_a;
   assign ev_a    = run && (match_p || cap_p
                    || (capc_ff.capture_source_sel && edge_b));
   assign ev_b    = run && (match_d || cap_d);
   // wrap flags a width beyond one counter period
   assign ev_ovf  = run && (cnt_ff == tmr_pkg::CNT_MAX) && !cnt_clr;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= '0;
      end else if (clk_en && (mode == tmr_pkg::MODE_STOP)) begin
         cnt_ff <= '0;
      end else if (run) begin
         cnt_ff <= cnt_clr ? '0 : cnt_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output pin

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_ff <= 1'b0;
         os_ff  <= tmr_pkg::OS_IDLE;
      end else if (clk_en) begin
         if (!ctrl_ff.out_en || (mode == tmr_pkg::MODE_STOP)) begin
            out_ff <= 1'b0;
            os_ff  <= tmr_pkg::OS_IDLE;
         end else if (run) begin
            if (ctrl_ff.oneshot_en) begin
               if (os_trig) begin
                  out_ff <= 1'b0;
                  os_ff  <= tmr_pkg::OS_WAIT;
               end else begin
                  case (os_ff)
                     tmr_pkg::OS_WAIT: begin
                        if (match_d) begin
                           out_ff <= 1'b1;
                           os_ff  <= tmr_pkg::OS_PULSE;
                        end
                     end
                     tmr_pkg::OS_PULSE: begin
                        if (match_p) begin
                           out_ff <= 1'b0;
                           os_ff  <= tmr_pkg::OS_IDLE;
                        end
                     end
                     default: os_ff <= tmr_pkg::OS_IDLE;
                  endcase
               end
            end else if (ctrl_ff.ppg_mode) begin
               // high over counts 0..duty, low over duty+1..period
               if (match_p) begin
                  out_ff <= 1'b1;
               end else if (match_d) begin
                  out_ff <= 1'b0;
               end
            end else if (match_p) begin
               out_ff <= !out_ff;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // control registers

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_ff <= '0;
      end else if (clk_en && wr_ctrl) begin
         ctrl_ff <= tmr_pkg::ctrl_t'(reg_wdata[4:0]);
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         soft_pend_ff <= 1'b0;
      end else if (clk_en) begin
         if (wr_ctrl && reg_wdata[tmr_pkg::SOFT_TRIG_BIT]) begin
            soft_pend_ff <= 1'b1;
         end else if (tick) begin
            soft_pend_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         capc_ff    <= '0;
         pre_sel_ff <= '0;
         mask_ff    <= '0;
      end else if (clk_en) begin
         if (wr_capc) begin
            capc_ff <= tmr_pkg::capc_t'(reg_wdata[6:0]);
         end
         if (wr_pre) begin
            pre_sel_ff <= reg_wdata[1:0];
         end
         if (wr_mask) begin
            mask_ff <= tmr_pkg::stat_t'(reg_wdata[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // compare / capture registers: a capture beats a write

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         per_ff <= tmr_pkg::PER_RST;
      end else if (clk_en) begin
         if (run && cap_p) begin
            per_ff <= cnt_ff;
         end else if (wr_per) begin
            per_ff <= reg_wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         duty_ff <= tmr_pkg::DUTY_RST;
      end else if (clk_en) begin
         if (run && cap_d) begin
            duty_ff <= cnt_ff;
         end else if (wr_duty) begin
            duty_ff <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // interrupts

   tmr_pkg::stat_t ev;
   tmr_pkg::stat_t clr;
   tmr_pkg::stat_t nxt_stat;

   always_comb begin
      ev       = '{ovf: ev_ovf, evt_b: ev_b, evt_a: ev_a};
      clr      = wr_stat ? tmr_pkg::stat_t'(reg_wdata[2:0]) : '0;
      nxt_stat = (stat_ff & ~clr) | ev;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_ff <= '0;
         irq_ff  <= 1'b0;
      end else if (clk_en) begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(nxt_stat & mask_ff);
      end
   end

   // refreshed only at count clock ticks, so it lasts one count clock
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irqa_ff <= 1'b0;
      end else if (clk_en && tick) begin
         irqa_ff <= ev_a;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_ff <= '0;
      end else if (clk_en) begin
         if (!reg_rd) begin
            rdata_ff <= '0;
         end else if (reg_addr == tmr_pkg::OFS_CTRL) begin
            rdata_ff <= {11'h000, ctrl_ff};
         end else if (reg_addr == tmr_pkg::OFS_PER) begin
            rdata_ff <= per_ff;
         end else if (reg_addr == tmr_pkg::OFS_DUTY) begin
            rdata_ff <= duty_ff;
         end else if (reg_addr == tmr_pkg::OFS_CAPC) begin
            rdata_ff <= {9'h000, capc_ff};
         end else if (reg_addr == tmr_pkg::OFS_CNT) begin
            rdata_ff <= cnt_ff;
         end else if (reg_addr == tmr_pkg::OFS_STAT) begin
            rdata_ff <= {13'h0000, stat_ff};
         end else if (reg_addr == tmr_pkg::OFS_MASK) begin
            rdata_ff <= {13'h0000, mask_ff};
         end else if (reg_addr == tmr_pkg::OFS_PRE) begin
            rdata_ff <= {14'h0000, pre_sel_ff};
         end else begin
            rdata_ff <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign reg_rdata           = rdata_ff;
   assign timer_output_pin    = out_ff;
   assign match_capture_irq_a = irqa_ff;
   assign irq                 = irq_ff;

endmodule
`default_nettype wire

// >>> src/tmr_edge_filter.sv
// noise filter and edge detector for one capture input
`timescale 1ns/100ps
`default_nettype none
module tmr_edge_filter (
   input  wire logic ref_clk,   // clock
   input  wire logic sys_rst,   // async reset
   input  wire logic clk_en,    // freeze when low
   input  wire logic tick,      // sampling clock enable
   input  wire logic pin,       // raw input
   output logic      rise,      // accepted rising edge
   output logic      fall       // accepted falling edge
);

   logic samp_ff;
   logic lvl_ff;
   logic agree;

   // a new level counts only after two equal samples
   assign agree = tick && (pin == samp_ff) && (pin != lvl_ff);
   assign rise  = agree && pin;
   assign fall  = agree && !pin;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         samp_ff <= 1'b0;
         lvl_ff  <= 1'b0;
      end else if (clk_en && tick) begin
         samp_ff <= pin;
         if (agree) begin
            lvl_ff <= pin;
         end
      end
   end

endmodule
`default_nettype wire

// >>> src/tmr_pkg.sv
// constants, types and register map of the capture/compare timer
// How it works
// - one counter wrap bounds measurable width
// - ppg period is P+1, high is D+1 in match-clear mode
// - input edge still triggers soft one-shot
// - nonzero mode field starts counting at once
// - first match may slip one count clock
// - one-shot only in free-run or edge-clear
// - source select plus both edges: no period capture
// - source select: b edge raises irq only
// - capture edge needs two equal samples
package tmr_pkg;

   localparam int DW = 16;
   localparam int AW = 4;

   localparam logic [3:0] OFS_CTRL  = 4'h0;
   localparam logic [3:0] OFS_PER   = 4'h1;
   localparam logic [3:0] OFS_DUTY  = 4'h2;
   localparam logic [3:0] OFS_CAPC  = 4'h3;
   localparam logic [3:0] OFS_CNT   = 4'h4;
   localparam logic [3:0] OFS_STAT  = 4'h5;
   localparam logic [3:0] OFS_MASK  = 4'h6;
   localparam logic [3:0] OFS_PRE   = 4'h7;

   localparam int SOFT_TRIG_BIT = 5;

   localparam logic [15:0] PER_RST  = 16'hffff;
   localparam logic [15:0] DUTY_RST = 16'h0000;
   localparam logic [15:0] CNT_MAX  = 16'hffff;

   localparam int PRE_W = 6;

   typedef enum logic [1:0] {
      MODE_STOP  = 2'b00,
      MODE_CLR_E = 2'b01,
      MODE_FREE  = 2'b10,
      MODE_CLR_M = 2'b11
   } op_mode_t;

   typedef enum logic [1:0] {
      EDGE_FALL = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_NONE = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;

   typedef enum logic [1:0] {
      OS_IDLE  = 2'b00,
      OS_WAIT  = 2'b01,
      OS_PULSE = 2'b11
   } os_state_t;

   typedef struct packed {
      logic       oneshot_en;
      logic       ppg_mode;
      logic       out_en;
      logic       op_mode_bit_hi;
      logic       op_mode_bit_lo;
   } ctrl_t;

   typedef struct packed {
      edge_sel_t  edge_b;
      edge_sel_t  edge_a;
      logic       duty_cap_en;
      logic       capture_source_sel;
      logic       per_cap_en;
   } capc_t;

   typedef struct packed {
      logic       ovf;
      logic       evt_b;
      logic       evt_a;
   } stat_t;

endpackage
